/* hdl/tws_pkg.sv */
// Constants, register map and state type of the two-wire slave unit
package tws_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] TWS_OFS_OWN = 4'h0;  // slave_own_address
  localparam logic [3:0] TWS_OFS_CTRL = 4'h1; // serial_control
  localparam logic [3:0] TWS_OFS_STAT = 4'h2; // serial_status
  localparam logic [3:0] TWS_OFS_DATA = 4'h3; // serial_data_byte

  // ----------------------------------------------------------------
  // Field positions of serial_control and slave_own_address
  // ----------------------------------------------------------------
  localparam int TWS_CTRL_FLAG = 7; // step_done_flag
  localparam int TWS_CTRL_ACK = 6;  // ack_enable
  localparam int TWS_CTRL_STA = 5;  // start_request
  localparam int TWS_CTRL_STO = 4;  // stop_request
  localparam int TWS_CTRL_WCOL = 3; // write_collision_flag
  localparam int TWS_CTRL_EN = 2;   // interface_enable
  localparam int TWS_CTRL_IE = 0;   // irq_enable
  localparam int TWS_OWN_GCE = 0;   // general_call_enable

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] TWS_OWN_RST = 8'h00;
  localparam logic [7:0] TWS_DATA_RST = 8'hff;
  localparam logic [7:0] TWS_STAT_MASK = 8'hf8; // Prescaler field reads zero

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TWS_ST_SLA_W = 8'h60;
  localparam logic [7:0] TWS_ST_ARB_SLA_W = 8'h68;
  localparam logic [7:0] TWS_ST_GC_W = 8'h70;
  localparam logic [7:0] TWS_ST_ARB_GC_W = 8'h78;
  localparam logic [7:0] TWS_ST_RX_ACK = 8'h80;
  localparam logic [7:0] TWS_ST_RX_NACK = 8'h88;
  localparam logic [7:0] TWS_ST_GC_ACK = 8'h90;
  localparam logic [7:0] TWS_ST_GC_NACK = 8'h98;
  localparam logic [7:0] TWS_ST_STOP = 8'ha0;
  localparam logic [7:0] TWS_ST_SLA_R = 8'ha8;
  localparam logic [7:0] TWS_ST_ARB_SLA_R = 8'hb0;
  localparam logic [7:0] TWS_ST_TX_ACK = 8'hb8;
  localparam logic [7:0] TWS_ST_TX_NACK = 8'hc0;
  localparam logic [7:0] TWS_ST_TX_LAST = 8'hc8;
  localparam logic [7:0] TWS_ST_NONE = 8'hf8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TWS_CLK_PERIOD_NS = 10;
  localparam int TWS_START_HOLD_NS = 4000; // Own start: data low with clock high
  localparam int TWS_START_HOLD_CYC =
    (TWS_START_HOLD_NS + TWS_CLK_PERIOD_NS - 1) / TWS_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Bus-side state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    TWS_IDLE = 8'h01, // Not addressed, monitoring
    TWS_ADDR = 8'h02, // Shifting in address and direction
    TWS_AACK = 8'h04, // Acknowledging own or general call address
    TWS_RX = 8'h08,   // Receiving a data byte
    TWS_RACK = 8'h10, // Answer bit after a received byte
    TWS_TX = 8'h20,   // Sending a data byte
    TWS_TACK = 8'h40, // Sampling the master's answer
    TWS_HOLD = 8'h80  // Flag set, clock stretched
  } tws_state_type;

endpackage

/* hdl/tws_slave.sv */
// Two-wire slave unit: address match, slave receive tail and slave transmit
//
// Function
// - Match address against own-address upper seven bits
// - Own-address bit zero enables general call
// - Direction one enters transmit, else receive
// - Address received sets flag with status code
// - Prescaler bits of status read zero
// - Arbitration lost then read reports 0xB0
// - Ack cleared: last byte, then 0xC0/0xC8
// - After last byte release data line
// - Ack disabled: ignore own address, keep monitoring
// - Sleep: still acknowledge own or general call
// - Sleep match wakes, clock held until clear
// - Data byte not updated while asleep
// - 0x90 general call byte acked, ack next
// - 0x98 general call byte nacked, then unaddressed
// - 0xA0 stop or restart while addressed
// - Unaddressed recognition follows ack and general enable
// - Start request on clear sends start later
// - 0x88 own write byte nacked, then unaddressed
// - 0xA8 own read address acked, load byte
// - 0xB8 byte acked by master, load next
// - 0xC0 nack received, then unaddressed
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module tws_slave
  import tws_pkg::*;
#(
  parameter int unsigned START_CYC = TWS_START_HOLD_CYC // Own start hold length
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_pin,
  output logic scl_level,
  output logic scl_drive,
  input wire logic sda_pin,
  output logic sda_level,
  output logic sda_drive,
  input wire logic sleep_req,
  input wire logic arb_lost,
  output logic wake
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q; // Clock line synchroniser and history
  logic sda_s1_q, sda_s2_q, sda_s3_q; // Data line synchroniser and history
  tws_state_type state_q, state_d;    // Bus-side state
  logic [2:0] cnt_q, cnt_d;           // Bit counter
  logic [7:0] sh_q, sh_d;             // Shift register
  logic [7:0] code_q, code_d;         // Latched status code
  logic gc_q, gc_d;                   // Addressed by general call
  logic dir_q, dir_d;                 // Direction bit of the address
  logic plan_q, plan_d;               // Acknowledge the byte in flight
  logic last_q, last_d;               // Byte in flight is the last one
  logic mack_q, mack_d;               // Master acknowledged
  logic seen_q, seen_d;               // Address bit clocked in since the start
  logic flag_q;                       // step_done_flag
  logic ack_en_q, sta_q, sto_q, en_q, ie_q; // serial_control bits
  logic wcol_q;                       // write_collision_flag
  logic [7:0] own_q;                  // slave_own_address
  logic [7:0] data_q;                 // serial_data_byte
  logic busy_q;                       // Bus between start and stop
  logic pend_q;                       // Own start waiting for free bus
  logic gen_q;                        // Own start in progress
  logic [15:0] gen_cnt_q;             // Own start hold counter
  logic flag_set, hit, rx_store, pend_set, addressed;
  logic ctrl_wr, flag_clr, data_wr;
  logic scl_rise, scl_fall, start_det, stop_det, addr_match;

  // ----------------------------------------------------------------
  // Line synchronisers and bus event detection
  // ----------------------------------------------------------------
  // Two flops per line, a third one only for edge history
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
    end
    else
    begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_pin, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_pin, sda_s1_q, sda_s2_q};
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign stop_det = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  // Register port strobes
  assign ctrl_wr = reg_wr && (reg_addr == TWS_OFS_CTRL);
  assign flag_clr = ctrl_wr && reg_wdata[TWS_CTRL_FLAG];
  assign data_wr = reg_wr && (reg_addr == TWS_OFS_DATA);

  // Own address or enabled general call, only with ack enabled
  assign addr_match = en_q && ack_en_q &&
    ((sh_q[7:1] == own_q[7:1]) ||
     ((sh_q[7:1] == 7'h00) && own_q[TWS_OWN_GCE]));

  // Addressed unless idle, shifting an address or parked after a final code
  assign addressed = !(state_q == TWS_IDLE || state_q == TWS_ADDR) &&
    !(state_q == TWS_HOLD && (code_q == TWS_ST_RX_NACK || code_q == TWS_ST_GC_NACK ||
      code_q == TWS_ST_TX_NACK || code_q == TWS_ST_TX_LAST));

  // ----------------------------------------------------------------
  // Bus-side next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    code_d = code_q;
    gc_d = gc_q;
    dir_d = dir_q;
    plan_d = plan_q;
    last_d = last_q;
    mack_d = mack_q;
    seen_d = seen_q;
    flag_set = 1'b0;
    hit = 1'b0;
    rx_store = 1'b0;
    pend_set = 1'b0;
    unique case (state_q)
      TWS_IDLE:
      begin
        // Wait for a start, handled below; a stop report cleared here may ask for a start
        if (flag_clr && flag_q && code_q == TWS_ST_STOP)
          pend_set = reg_wdata[TWS_CTRL_STA];
      end
      TWS_ADDR:
      begin
        // The clock fall that closes the start condition is not a bit
        if (scl_rise)
        begin
          sh_d = {sh_q[6:0], sda_s2_q};
          seen_d = 1'b1;
        end
        else if (scl_fall && seen_q)
        begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7)
          begin
            if (addr_match)
            begin
              hit = 1'b1;
              state_d = TWS_AACK;
              gc_d = (sh_q[7:1] == 7'h00);
              dir_d = sh_q[0];
            end
            else
              state_d = TWS_IDLE;
          end
        end
      end
      TWS_AACK:
      begin
        // Address acknowledged: report and pick the mode
        if (scl_fall)
        begin
          flag_set = 1'b1;
          state_d = TWS_HOLD;
          if (dir_q)
            code_d = arb_lost ? TWS_ST_ARB_SLA_R : TWS_ST_SLA_R;
          else if (gc_q)
            code_d = arb_lost ? TWS_ST_ARB_GC_W : TWS_ST_GC_W;
          else
            code_d = arb_lost ? TWS_ST_ARB_SLA_W : TWS_ST_SLA_W;
        end
      end
      TWS_RX:
      begin
        if (scl_rise)
          sh_d = {sh_q[6:0], sda_s2_q};
        else if (scl_fall)
        begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7)
            state_d = TWS_RACK;
        end
      end
      TWS_RACK:
      begin
        // Answer bit done: report the received byte
        if (scl_fall)
        begin
          flag_set = 1'b1;
          rx_store = 1'b1;
          state_d = TWS_HOLD;
          if (gc_q)
            code_d = plan_q ? TWS_ST_GC_ACK : TWS_ST_GC_NACK;
          else
            code_d = plan_q ? TWS_ST_RX_ACK : TWS_ST_RX_NACK;
        end
      end
      TWS_TX:
      begin
        // Next bit goes out after each falling clock edge
        if (scl_fall)
        begin
          cnt_d = cnt_q + 3'h1;
          sh_d = {sh_q[6:0], 1'b1};
          if (cnt_q == 3'h7)
            state_d = TWS_TACK;
        end
      end
      TWS_TACK:
      begin
        if (scl_rise)
          mack_d = ~sda_s2_q;
        else if (scl_fall)
        begin
          flag_set = 1'b1;
          state_d = TWS_HOLD;
          if (!mack_q)
            code_d = TWS_ST_TX_NACK;
          else if (last_q)
            code_d = TWS_ST_TX_LAST;
          else
            code_d = TWS_ST_TX_ACK;
        end
      end
      TWS_HOLD:
      begin
        // Software cleared the flag: start the next bus action
        if (flag_clr)
        begin
          cnt_d = 3'h0;
          if (code_q == TWS_ST_SLA_W || code_q == TWS_ST_ARB_SLA_W ||
              code_q == TWS_ST_GC_W || code_q == TWS_ST_ARB_GC_W ||
              code_q == TWS_ST_RX_ACK || code_q == TWS_ST_GC_ACK)
          begin
            state_d = TWS_RX;
            plan_d = reg_wdata[TWS_CTRL_ACK];
          end
          else if (code_q == TWS_ST_SLA_R || code_q == TWS_ST_ARB_SLA_R ||
                   code_q == TWS_ST_TX_ACK)
          begin
            state_d = TWS_TX;
            sh_d = data_q;
            last_d = ~reg_wdata[TWS_CTRL_ACK];
          end
          else
          begin
            state_d = TWS_IDLE;
            pend_set = reg_wdata[TWS_CTRL_STA];
          end
        end
      end
    endcase
    // Bus conditions override the bit sequence
    if (start_det)
    begin
      if (addressed)
      begin
        flag_set = 1'b1;
        code_d = TWS_ST_STOP;
      end
      state_d = TWS_ADDR;
      cnt_d = 3'h0;
      seen_d = 1'b0;
    end
    else if (stop_det)
    begin
      if (addressed)
      begin
        flag_set = 1'b1;
        code_d = TWS_ST_STOP;
      end
      state_d = TWS_IDLE;
    end
    // Disabled unit stays idle and reports nothing
    if (!en_q)
    begin
      state_d = TWS_IDLE;
      flag_set = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus-side state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= TWS_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      code_q <= TWS_ST_NONE;
      gc_q <= 1'b0;
      dir_q <= 1'b0;
      plan_q <= 1'b0;
      last_q <= 1'b0;
      mack_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      code_q <= code_d;
      gc_q <= gc_d;
      dir_q <= dir_d;
      plan_q <= plan_d;
      last_q <= last_d;
      mack_q <= mack_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Step done flag: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (flag_set)
      flag_q <= 1'b1;
    else if (flag_clr)
      flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control and own-address registers
  // ----------------------------------------------------------------
  // Control bits keep their written values; start request ends with own start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {ack_en_q, sta_q, sto_q, en_q, ie_q} <= 5'h00;
    end
    else if (ctrl_wr)
    begin
      ack_en_q <= reg_wdata[TWS_CTRL_ACK];
      sta_q <= reg_wdata[TWS_CTRL_STA];
      sto_q <= reg_wdata[TWS_CTRL_STO];
      en_q <= reg_wdata[TWS_CTRL_EN];
      ie_q <= reg_wdata[TWS_CTRL_IE];
    end
    else if (gen_q && (gen_cnt_q == 16'(START_CYC - 1)))
      sta_q <= 1'b0;
  end

  // Own address and general call enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      own_q <= TWS_OWN_RST;
    else if (reg_wr && (reg_addr == TWS_OFS_OWN))
      own_q <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // Data byte and write collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_q <= TWS_DATA_RST;
      wcol_q <= 1'b0;
    end
    else
    begin
      // Received byte is dropped while the system clock sleeps
      if (rx_store && !sleep_req)
        data_q <= sh_q;
      else if (data_wr && flag_q)
        data_q <= reg_wdata;
      // Loading while the flag is low is a collision
      if (data_wr)
        wcol_q <= !flag_q;
    end
  end

  // ----------------------------------------------------------------
  // Own start once the bus is free
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      gen_q <= 1'b0;
      gen_cnt_q <= 16'h0000;
    end
    else
    begin
      if (start_det)
        busy_q <= 1'b1;
      else if (stop_det)
        busy_q <= 1'b0;
      if (pend_set)
        pend_q <= 1'b1;
      // Hold data low with clock high for the start hold time
      if (gen_q)
      begin
        gen_cnt_q <= gen_cnt_q + 16'h0001;
        if (gen_cnt_q == 16'(START_CYC - 1))
        begin
          gen_q <= 1'b0;
          pend_q <= 1'b0;
        end
      end
      else if (pend_q && !busy_q && state_q == TWS_IDLE && scl_s2_q)
      begin
        gen_q <= 1'b1;
        gen_cnt_q <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and wake request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_level <= 1'b0;
      sda_level <= 1'b0;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      scl_level <= 1'b0;
      sda_level <= 1'b0;
      // Stretch clock low while software owns the step
      scl_drive <= (state_q == TWS_HOLD) && flag_q;
      // Pull data low for acks, zero bits and own start; released otherwise
      sda_drive <= (state_q == TWS_AACK) ||
        ((state_q == TWS_RACK) && plan_q) ||
        ((state_q == TWS_TX) && !sh_q[7]) || gen_q;
      // Address match in sleep asks for wake-up until the flag clears
      if (hit && sleep_req)
        wake <= 1'b1;
      else if (flag_clr)
        wake <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register read port, data valid one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        TWS_OFS_OWN: reg_rdata <= own_q;
        TWS_OFS_CTRL: reg_rdata <= {flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q, 1'b0, ie_q};
        TWS_OFS_STAT: reg_rdata <= (flag_q ? code_q : TWS_ST_NONE) & TWS_STAT_MASK;
        TWS_OFS_DATA: reg_rdata <= data_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_stat_none: assert property (reg_rd && reg_addr == TWS_OFS_STAT && !flag_q && !flag_set
    |=> reg_rdata == 8'hf8) else $error("idle status not 0xf8");
  a_presc_zero: assert property (reg_rd && reg_addr == TWS_OFS_STAT
    |=> reg_rdata[2:0] == 3'h0) else $error("prescaler bits nonzero");
  a_gc_enable: assert property ($rose(flag_q) && (code_q == TWS_ST_GC_W)
    |-> own_q[TWS_OWN_GCE]) else $error("general call answered while disabled");
  a_hit_ack: assert property (hit |-> ack_en_q && en_q ##1 state_q == TWS_AACK ##1 sda_drive)
    else $error("address acked without ack enable");
  a_stretch_hold: assert property (state_q == TWS_HOLD && flag_q |=> scl_drive)
    else $error("clock not stretched while flag set");
  a_flag_clear: assert property (flag_clr && !flag_set |=> !flag_q)
    else $error("flag not cleared by write of one");
  a_flag_keep: assert property (ctrl_wr && !reg_wdata[TWS_CTRL_FLAG] && flag_q |=> flag_q)
    else $error("flag cleared by write of zero");
  a_idle_release: assert property (state_q == TWS_IDLE && !gen_q |=> !sda_drive)
    else $error("data line driven while unaddressed");
  a_term_idle: assert property (state_q == TWS_HOLD && flag_clr && en_q && !start_det &&
    (code_q == TWS_ST_TX_NACK || code_q == TWS_ST_TX_LAST || code_q == TWS_ST_GC_NACK)
    |=> state_q == TWS_IDLE) else $error("not unaddressed after final code");
  a_read_mode: assert property (state_q == TWS_HOLD && flag_clr && en_q && !start_det &&
    !stop_det && (code_q == TWS_ST_SLA_R || code_q == TWS_ST_TX_ACK)
    |=> state_q == TWS_TX && last_q == !ack_en_q) else $error("transmit not entered");
  a_sleep_data: assert property (rx_store && sleep_req |=> $stable(data_q))
    else $error("data updated while asleep");

  c_read_addr: cover property ($rose(flag_q) && code_q == TWS_ST_SLA_R);
  c_last_acked: cover property ($rose(flag_q) && code_q == TWS_ST_TX_LAST);
  c_gc_byte: cover property ($rose(flag_q) && code_q == TWS_ST_GC_ACK);
  c_stop_seen: cover property ($rose(flag_q) && code_q == TWS_ST_STOP);

endmodule

/* verif/tws_mst.sv */
// Bus master model that drives both open-drain lines of the slave
`timescale 1ns/1ps

module tws_mst
(
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  // ------------------------------------------------
  // Master side of the bus, high = pulling line low
  // ------------------------------------------------
  initial {scl_pull, sda_pull} = 2'b00;
  // Set both pulls after n clock edges
  task automatic lines(input int n, input logic c, input logic d);
    repeat (n) @(posedge clk);
    scl_pull <= c;
    sda_pull <= d;
  endtask
  // Start: data falls while clock high, after some bus free time
  task automatic start();
    lines(8, 1'b0, 1'b1);
    lines(8, 1'b1, 1'b1);
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    lines(4, 1'b1, 1'b1);
    lines(8, 1'b0, 1'b1);
    lines(8, 1'b0, 1'b0);
  endtask
  // One bit of a 160 ns clock; a stretched clock is waited out
  task automatic bit_io(input logic b, output logic r);
    lines(4, 1'b1, !b);
    lines(4, 1'b0, !b);
    while (scl_line !== 1'b1) @(posedge clk);
    repeat (7) @(posedge clk);
    r = sda_line;
    lines(0, 1'b1, !b);
  endtask
  // Byte MSB first, direction bit last, then the answer bit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
    output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask
endmodule

/* verif/tws_slave_bench.sv */
// Self-checking bench of the two-wire slave unit
`timescale 1ns/1ps

module tws_slave_bench
  import tws_pkg::*;
;
  // ------------------------------------------------
  // Stimulus, wired-and lines and counters
  // ------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic arb_lost = 1'b0;
  logic [7:0] reg_rdata, got, dat;
  logic scl_drive, sda_drive, wake, m_scl, m_sda, k, scl_lv, sda_lv;
  logic [6:0] adr;
  wire scl_w = !(scl_drive || m_scl); // Pull-up unless pulled low
  wire sda_w = !(sda_drive || m_sda);
  int mismatches = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  tws_slave #(.START_CYC(4)) i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .scl_pin(scl_w), .scl_level(scl_lv), .scl_drive,
    .sda_pin(sda_w), .sda_level(sda_lv), .sda_drive, .sleep_req, .arb_lost, .wake);
  tws_mst i_mst (.clk, .scl_line(scl_w), .sda_line(sda_w), .scl_pull(m_scl),
    .sda_pull(m_sda));
  // Compare one value
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk("register", e, got);
  endtask
  // Poll status until a code shows, then compare it
  task automatic ev(input logic [7:0] e);
    got = TWS_ST_NONE;
    for (int i = 0; i < 400 && got === TWS_ST_NONE; i++) rd(TWS_OFS_STAT);
    chk("status", e, got);
  endtask
  // Start and address byte, compare the slave's answer bit
  task automatic ad(input logic [7:0] a, input logic e);
    i_mst.start();
    i_mst.xfer(a, 1'b1, got, k);
    chk("addr answer", {7'h0, e}, {7'h0, k});
  endtask
  // Load a random byte, clear with control c, master reads it
  task automatic send(input logic [7:0] c, input logic ma);
    dat = 8'($urandom);
    wr(TWS_OFS_DATA, dat);
    wr(TWS_OFS_CTRL, c);
    i_mst.xfer(8'hff, ma, got, k);
    chk("tx byte", dat, got);
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hung bus
  initial
  begin
    // Several times the longest expected run
    #300000;
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h78d7));
    adr = 7'($urandom_range(127, 1));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(TWS_OFS_OWN, TWS_OWN_RST);
    rc(TWS_OFS_DATA, TWS_DATA_RST);
    rc(TWS_OFS_STAT, TWS_ST_NONE);
    rc(4'h7, 8'h00);
    wr(TWS_OFS_OWN, {adr, 1'b1});
    wr(TWS_OFS_CTRL, 8'h44);
    rc(TWS_OFS_CTRL, 8'h44);
    ad({adr, 1'b1}, 1'b0);
    ev(TWS_ST_SLA_R);
    chk("stretch", 8'h01, {7'h0, scl_drive});
    chk("levels", 8'h00, {6'h0, scl_lv, sda_lv});
    send(8'hc4, 1'b0);
    ev(TWS_ST_TX_ACK);
    send(8'h84, 1'b0);
    ev(TWS_ST_TX_LAST);
    wr(TWS_OFS_CTRL, 8'hc4);
    i_mst.xfer(8'hff, 1'b1, got, k);
    chk("released", 8'hff, got);
    i_mst.stop();
    arb_lost <= 1'b1;
    ad({adr, 1'b1}, 1'b0);
    ev(TWS_ST_ARB_SLA_R);
    send(8'h84, 1'b1);
    ev(TWS_ST_TX_NACK);
    wr(TWS_OFS_CTRL, 8'hc4);
    arb_lost <= 1'b0;
    i_mst.stop();
    sleep_req <= 1'b1;
    ad(8'h00, 1'b0);
    ev(TWS_ST_GC_W);
    chk("wake", 8'h01, {7'h0, wake});
    sleep_req <= 1'b0;
    dat = 8'($urandom);
    wr(TWS_OFS_CTRL, 8'hc4);
    i_mst.xfer(dat, 1'b1, got, k);
    chk("wake", 8'h00, {7'h0, wake});
    ev(TWS_ST_GC_ACK);
    rc(TWS_OFS_DATA, dat);
    sleep_req <= 1'b1;
    wr(TWS_OFS_CTRL, 8'h84);
    i_mst.xfer(~dat, 1'b1, got, k);
    chk("gc nack", 8'h01, {7'h0, k});
    ev(TWS_ST_GC_NACK);
    rc(TWS_OFS_DATA, dat);
    sleep_req <= 1'b0;
    wr(TWS_OFS_CTRL, 8'hc4);
    i_mst.stop();
    rc(TWS_OFS_STAT, TWS_ST_NONE);
    ad({adr, 1'b0}, 1'b0);
    ev(TWS_ST_SLA_W);
    wr(TWS_OFS_CTRL, 8'h84);
    i_mst.xfer(dat, 1'b1, got, k);
    ev(TWS_ST_RX_NACK);
    wr(TWS_OFS_CTRL, 8'he4);
    i_mst.stop();
    repeat (20) @(posedge clk);
    rc(TWS_OFS_CTRL, 8'h44);
    arb_lost <= 1'b1;
    ad({adr, 1'b0}, 1'b0);
    ev(TWS_ST_ARB_SLA_W);
    wr(TWS_OFS_CTRL, 8'hc4);
    arb_lost <= 1'b0;
    i_mst.stop();
    ev(TWS_ST_STOP);
    wr(TWS_OFS_OWN, {adr, 1'b0});
    wr(TWS_OFS_CTRL, 8'h84);
    ad({adr, 1'b1}, 1'b1);
    i_mst.stop();
    wr(TWS_OFS_CTRL, 8'h44);
    ad(8'h00, 1'b1);
    i_mst.stop();
    stop_test();
  end
endmodule
